// File: rtl/sarmc_pkg.sv
// Behaviour
// - Convert only after acquisition done and start low
// - MSB-first search over sixteen binary weights
// - Output code and busy drop at the same edge
// - Each result ready at its own conversion end
// - Two select pins decode four modes
// - Low-power mode powers down after each conversion
// - Coding select picks binary or twos complement
// - Midscale plus one: 0x8001 or 0x0001
// - Midscale minus one: 0x7fff or 0xffff, MSB inverted
// - Out-of-range input saturates at full scale
// - Start falling edge holds sample, starts conversion
// - Reset input high aborts any conversion
// - Power-down finishes current, then refuses conversions
package sarmc_pkg;

    // Clock and timing
    localparam int CLK_MHZ = 40;
    localparam int ACQ_TIME_NS = 100;
    localparam int ACQ_CYCLES = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int GAP_TIME_NS = 1000000;
    localparam int GAP_CYCLES = (GAP_TIME_NS / 1000) * CLK_MHZ;

    // Result width and search start
    localparam int RES_W = 16;
    localparam logic [3:0] MSB_IDX = 4'hf;
    localparam logic [15:0] MIDSCALE = 16'h8000;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;

    // Control fields and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_DIV_LSB = 4;
    localparam logic [3:0] DIV_MIN = 4'h3;
    localparam logic [31:0] CTRL_RST = 32'h0000_0031;

    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_MODE_LSB = 1;
    localparam int ST_PWR_BIT = 3;
    localparam int ST_STALE_BIT = 4;
    localparam int ST_PDN_BIT = 5;

    // Operating modes, {fast_select, low_power_select}
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_LOWPWR = 2'b01,
        MODE_FAST = 2'b10,
        MODE_WIDEBAND = 2'b11
    } sarmc_mode_t;

    // Conversion sequencer states
    typedef enum logic [2:0] {
        ST_ACQ = 3'b000,
        ST_READY = 3'b001,
        ST_CONV = 3'b010,
        ST_DONE = 3'b011,
        ST_SLEEP = 3'b100
    } sarmc_state_t;

    // Synchronised pin levels
    typedef struct packed {
        logic start_n;
        logic fast_sel;
        logic lowpwr_sel;
        logic coding_sel;
        logic pdown;
        logic reset_in;
        logic comp;
    } sarmc_pins_t;

endpackage

// File: rtl/sarmc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sarmc_top #(
    parameter int GAP_LIMIT = sarmc_pkg::GAP_CYCLES // Fast-mode idle gap in cycles
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic nrst, // Synchronous reset, active low
    input wire logic conversion_start_n, // Conversion start pin, active low
    input wire logic fast_select, // Speed select pin
    input wire logic low_power_select, // Power select pin
    input wire logic output_coding_select, // High binary, low twos complement
    input wire logic power_down_input, // Power-down pin, active high
    input wire logic reset_input, // Abort pin, active high
    input wire logic comparator_in, // Comparator: input at or above trial
    output logic [15:0] dac_switch, // Capacitor array switch levels
    output logic sample_hold, // High while sample is held
    output logic analog_on, // Internal circuits powered
    output logic busy, // Conversion in progress
    output logic [15:0] result_code, // Coded result of last conversion
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error
);

    // Two-flop synchronisers for every pin; reset to idle levels (start high, rest low)
    // so that no false start edge, abort or power-down shows up after reset
    sarmc_pkg::sarmc_pins_t sync1_ff, sync2_ff, prev_ff;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync1_ff <= 7'h40;
            sync2_ff <= 7'h40;
            prev_ff <= 7'h40;
        end else begin
            sync1_ff <= {conversion_start_n, fast_select, low_power_select, output_coding_select,
                         power_down_input, reset_input, comparator_in};
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // Binary or twos complement from the straight search value
    function automatic logic [15:0] code_of(input logic [15:0] sar, input logic binary);
        code_of = binary ? sar : {~sar[15], sar[14:0]};
    endfunction

    sarmc_pkg::sarmc_state_t state_ff, nxt_state;
    logic [15:0] sar_ff, nxt_sar;
    logic [3:0] bit_ff, nxt_bit;
    logic [3:0] tick_ff, nxt_tick;
    logic [7:0] acq_ff, nxt_acq;
    logic [31:0] ctrl_ff;
    logic [31:0] count_ff;
    logic [31:0] gap_ff;
    logic stale_ff, pend_stale_ff;
    logic [15:0] result_ff;

    // Mode decode from the two select pins
    wire sarmc_pkg::sarmc_mode_t mode = sarmc_pkg::sarmc_mode_t'({sync2_ff.fast_sel, sync2_ff.lowpwr_sel});
    wire fast_mode = (mode == sarmc_pkg::MODE_FAST) || (mode == sarmc_pkg::MODE_WIDEBAND);
    wire lowpwr_mode = (mode == sarmc_pkg::MODE_LOWPWR);
    wire start_fall = prev_ff.start_n && !sync2_ff.start_n;
    wire enabled = ctrl_ff[sarmc_pkg::CTRL_EN_BIT];
    wire [3:0] div_raw = ctrl_ff[sarmc_pkg::CTRL_DIV_LSB +: 4];
    // Short dividers would beat the comparator synchroniser, so clamp
    wire [3:0] div_eff = (div_raw < sarmc_pkg::DIV_MIN) ? sarmc_pkg::DIV_MIN : div_raw;
    wire tick = (tick_ff == div_eff);
    wire acq_done = (acq_ff >= 8'(sarmc_pkg::ACQ_CYCLES));
    wire accept = (state_ff == sarmc_pkg::ST_READY || state_ff == sarmc_pkg::ST_SLEEP)
                  && start_fall && enabled && !sync2_ff.pdown;
    wire [15:0] step = 16'h0001 << bit_ff;
    // Keep the trial bit when the input sits at or above the trial level
    wire [15:0] kept = sync2_ff.comp ? sar_ff : (sar_ff & ~step);
    wire gap_over = (gap_ff >= 32'(GAP_LIMIT));

    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_sar = sar_ff;
        nxt_bit = bit_ff;
        nxt_tick = tick ? 4'h0 : tick_ff + 4'h1;
        nxt_acq = acq_done ? acq_ff : acq_ff + 8'h01;
        unique case (state_ff)
            sarmc_pkg::ST_ACQ: begin
                if (acq_done) begin
                    nxt_state = lowpwr_mode ? sarmc_pkg::ST_SLEEP : sarmc_pkg::ST_READY;
                end
            end
            sarmc_pkg::ST_READY, sarmc_pkg::ST_SLEEP: begin
                if (accept) begin
                    nxt_state = sarmc_pkg::ST_CONV;
                    nxt_sar = sarmc_pkg::MIDSCALE;
                    nxt_bit = sarmc_pkg::MSB_IDX;
                    nxt_tick = 4'h0;
                end else begin
                    nxt_state = lowpwr_mode ? sarmc_pkg::ST_SLEEP : sarmc_pkg::ST_READY;
                end
            end
            sarmc_pkg::ST_CONV: begin
                if (tick) begin
                    if (bit_ff == 4'h0) begin
                        nxt_sar = kept;
                        nxt_state = sarmc_pkg::ST_DONE;
                    end else begin
                        nxt_sar = kept | (step >> 1);
                        nxt_bit = bit_ff - 4'h1;
                    end
                end
            end
            sarmc_pkg::ST_DONE: begin
                nxt_acq = 8'h00;
                nxt_state = sarmc_pkg::ST_ACQ;
            end
            default: begin
                nxt_state = sarmc_pkg::ST_ACQ;
            end
        endcase
        // Abort wins over everything else
        if (sync2_ff.reset_in) begin
            nxt_state = sarmc_pkg::ST_ACQ;
            nxt_acq = 8'h00;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_ff <= sarmc_pkg::ST_ACQ;
            sar_ff <= 16'h0000;
            bit_ff <= 4'h0;
            tick_ff <= 4'h0;
            acq_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            sar_ff <= nxt_sar;
            bit_ff <= nxt_bit;
            tick_ff <= nxt_tick;
            acq_ff <= nxt_acq;
        end
    end

    // Result code, updated only in the cycle the search ends
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            result_ff <= 16'h0000;
            count_ff <= 32'h0000_0000;
        end else if (state_ff == sarmc_pkg::ST_DONE) begin
            result_ff <= code_of(sar_ff, sync2_ff.coding_sel);
            count_ff <= count_ff + 32'h0000_0001;
        end
    end

    // Pin outputs; the result code appears at the edge where busy drops
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dac_switch <= 16'h0000;
            sample_hold <= 1'b0;
            busy <= 1'b0;
            analog_on <= 1'b1;
            result_code <= 16'h0000;
        end else begin
            dac_switch <= (nxt_state == sarmc_pkg::ST_CONV) ? nxt_sar : 16'h0000;
            sample_hold <= (nxt_state == sarmc_pkg::ST_CONV) || (state_ff == sarmc_pkg::ST_CONV);
            busy <= (nxt_state == sarmc_pkg::ST_CONV) || (state_ff == sarmc_pkg::ST_CONV);
            // Low-power mode sleeps after each conversion until next start
            analog_on <= !((nxt_state == sarmc_pkg::ST_SLEEP) || sync2_ff.pdown);
            // No latency: the code of this conversion is out as busy falls
            result_code <= (state_ff == sarmc_pkg::ST_DONE) ? code_of(sar_ff, sync2_ff.coding_sel) : result_code;
        end
    end

    // Fast-mode idle gap, marks the next result as one to discard
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gap_ff <= 32'h0000_0000;
            pend_stale_ff <= 1'b0;
            stale_ff <= 1'b0;
        end else begin
            gap_ff <= accept ? 32'h0000_0000 : (gap_over ? gap_ff : gap_ff + 32'h0000_0001);
            if (accept) begin
                pend_stale_ff <= fast_mode && gap_over;
            end
            if (state_ff == sarmc_pkg::ST_DONE) begin
                stale_ff <= pend_stale_ff;
            end
        end
    end

    // SLEEP is the ready state of low-power mode; a start wakes the circuits
    // at the same edge that begins the conversion.

    // APB decode; one wait state so read data comes from a flop
    wire access = psel && penable && !pready;
    wire hit_ctrl = (paddr == sarmc_pkg::OFS_CTRL);
    wire hit_status = (paddr == sarmc_pkg::OFS_STATUS);
    wire hit_result = (paddr == sarmc_pkg::OFS_RESULT);
    wire hit_count = (paddr == sarmc_pkg::OFS_COUNT);
    wire mapped = hit_ctrl || hit_status || hit_result || hit_count;
    wire [31:0] status_word = {26'h0, sync2_ff.pdown, stale_ff, !analog_on,
                               mode, busy};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                         hit_status ? status_word :
                         hit_result ? {16'h0000, result_ff} :
                         hit_count ? count_ff : 32'h0000_0000;

    // APB answer and control register
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            ctrl_ff <= sarmc_pkg::CTRL_RST;
        end else begin
            pready <= access;
            pslverr <= access && !mapped;
            prdata <= (access && !pwrite) ? rd_mux : 32'h0000_0000;
            // Write lands at the completion edge, where the master sees pready
            if (psel && penable && pready && pwrite && hit_ctrl) begin
                ctrl_ff <= {24'h0, pwdata[7:4], 3'h0, pwdata[0]};
            end
        end
    end

endmodule // sarmc_top
`default_nettype wire

// File: bench/sarmc_front.sv
`timescale 1ns/1ps
`default_nettype none
// Analog side model: tracks input, holds it, compares against the trial code
module sarmc_front (
    input wire logic clk_sys, // System clock
    input wire logic [16:0] level, // Input level, above 0xffff is overrange
    input wire logic under, // Input below negative full scale
    input wire logic sample_hold, // Hold request from the converter
    input wire logic [15:0] dac_switch, // Trial code
    output logic comparator_in // Held input at or above trial
);
    logic [16:0] held_ff;
    logic under_ff;
    // Track only while not held, so a late hold shows up as a wrong code
    always_ff @(posedge clk_sys) begin
        if (!sample_hold) begin
            held_ff <= level;
            under_ff <= under;
        end
    end
    assign comparator_in = !under_ff && (held_ff >= {1'b0, dac_switch});
endmodule // sarmc_front
`default_nettype wire

// File: bench/sarmc_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sarmc_top_assertions (
    input wire logic clk_sys, // System clock
    input wire logic nrst, // Sync reset, active low
    input wire logic conversion_start_n, // Start pin
    input wire logic power_down_input, // Power-down pin
    input wire logic fast_select, // Speed select pin
    input wire logic low_power_select, // Power select pin
    input wire logic reset_input, // Abort pin
    input wire logic [15:0] dac_switch, // Trial code
    input wire logic sample_hold, // Hold state
    input wire logic analog_on, // Circuits powered
    input wire logic busy, // Conversion running
    input wire logic [15:0] result_code, // Result
    input wire logic pready, // APB ready
    input wire logic pslverr // APB error
);
    logic [3:0] since_fall_ff;
    logic [7:0] busy_len_ff;
    // Saturating counters; reset leaves the start count high so no stale cause
    always_ff @(posedge clk_sys) begin
        since_fall_ff <= !nrst ? 4'hf : $fell(conversion_start_n) ? 4'h0 : since_fall_ff + {3'h0, since_fall_ff != 4'hf};
        busy_len_ff <= busy ? busy_len_ff + {7'h0, busy_len_ff != 8'hff} : 8'h00;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_start_cause: assert property ($rose(busy) |-> since_fall_ff <= 4'h6) else $error("busy rose without a start");
    a_hold_msb: assert property ($rose(busy) |-> sample_hold && dac_switch == 16'h8000) else $error("bad conversion entry");
    a_conv_length: assert property ($fell(busy) && !reset_input |-> busy_len_ff >= 8'h40) else $error("search too short");
    a_busy_held: assert property (busy |-> sample_hold) else $error("busy without hold");
    a_result_steady: assert property (busy |-> $stable(result_code)) else $error("result moved mid conversion");
    a_abort_busy: assert property (reset_input [*6] |-> !busy) else $error("abort ignored");
    a_pd_refuse: assert property (power_down_input [*6] ##0 !busy |=> !busy) else $error("start taken in power-down");
    a_pd_analog: assert property (power_down_input [*6] |-> !analog_on) else $error("circuits still on");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_lp_sleep: assert property ($fell(busy) && low_power_select && !fast_select && !reset_input
        && !power_down_input |-> ##5 !analog_on) else $error("no sleep after conversion");
endmodule // sarmc_top_assertions
bind sarmc_top sarmc_top_assertions sarmc_top_assertions_i (.clk_sys, .nrst, .conversion_start_n, .power_down_input,
    .fast_select, .low_power_select,
    .reset_input, .dac_switch, .sample_hold, .analog_on, .busy, .result_code, .pready, .pslverr);
`default_nettype wire

// File: bench/sarmc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sarmc_top_tb;
    logic clk_sys = 1'b0, nrst = 1'b0, conversion_start_n = 1'b1, fast_select = 1'b0, low_power_select = 1'b0;
    logic output_coding_select = 1'b1, power_down_input = 1'b0, reset_input = 1'b0, comparator_in, sample_hold;
    logic analog_on, busy, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er, under = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [15:0] dac_switch, result_code;
    logic [16:0] level = 17'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int errors = 0, checks_done = 0;
    always #12.5 clk_sys = ~clk_sys;
    // Short gap so the stale path is reachable in a short run
    // Above back-to-back spacing (about 80 cycles), short enough to reach in a run
    sarmc_top #(.GAP_LIMIT(200)) sarmc_top_i (.clk_sys, .nrst, .conversion_start_n, .fast_select, .low_power_select,
        .output_coding_select, .power_down_input, .reset_input, .comparator_in, .dac_switch, .sample_hold, .analog_on,
        .busy, .result_code, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    sarmc_front sarmc_front_i (.clk_sys, .level, .under, .sample_hold, .dac_switch, .comparator_in);
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    // One APB transfer; answer taken at the rising edge where pready is high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        rd = prdata;
        er = pslverr;
        check({31'h0, pready}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait out acquisition, start, wait bounded for busy to rise and fall
    task automatic conv(input logic [16:0] lvl, input logic und, input logic cod, input logic [15:0] want);
        int n;
        n = 0;
        @(posedge clk_sys);
        level <= lvl;
        under <= und;
        output_coding_select <= cod;
        repeat (8) @(posedge clk_sys);
        conversion_start_n <= 1'b0;
        do @(negedge clk_sys); while (busy !== 1'b1 && ++n < 10);
        check({31'h0, busy}, 32'h1);
        @(posedge clk_sys);
        conversion_start_n <= 1'b1;
        do @(negedge clk_sys); while (busy !== 1'b0 && ++n < 300);
        check({15'h0, busy, result_code}, {16'h0, want});
    endtask
    task automatic t_codes;
        logic [16:0] lv [5] = '{17'h08001, 17'h08000, 17'h07fff, 17'h1ffff, 17'h00000};
        logic [15:0] sb [5] = '{16'h8001, 16'h8000, 16'h7fff, 16'hffff, 16'h0000};
        logic [15:0] tc [5] = '{16'h0001, 16'h0000, 16'hffff, 16'h7fff, 16'h8000};
        for (int c = 0; c < 2; c++) begin
            for (int i = 0; i < 5; i++) begin
                conv(lv[i], i == 4, c[0], c[0] ? sb[i] : tc[i]);
            end
        end
        $display("codes test done");
    endtask
    // Start after acquisition, abort mid search: no busy, no new result
    task automatic t_abort;
        repeat (9) @(posedge clk_sys);
        conversion_start_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({31'h0, busy}, 32'h1);
        reset_input <= 1'b1;
        conversion_start_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check({15'h0, busy, result_code}, 32'h0);
        reset_input <= 1'b0;
        conv(17'h08001, 1'b0, 1'b1, 16'h8001);
        $display("abort test done");
    endtask
    // Power-down raised mid conversion: that one finishes, the next is refused
    task automatic t_pd;
        fork
            conv(17'h08001, 1'b0, 1'b1, 16'h8001);
            begin
                do @(posedge clk_sys); while (busy !== 1'b1);
                power_down_input <= 1'b1;
            end
        join
        repeat (6) @(posedge clk_sys);
        conversion_start_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        check({30'h0, busy, analog_on}, 32'h0);
        conversion_start_n <= 1'b1;
        power_down_input <= 1'b0;
        $display("power-down test done");
    endtask
    // Low-power sleep between conversions; a long fast-mode gap flags one result
    task automatic t_modes;
        @(posedge clk_sys);
        low_power_select <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            conv(17'h08000, 1'b0, 1'b1, 16'h8000);
            repeat (8) @(posedge clk_sys);
            check({31'h0, analog_on}, 32'h0);
        end
        low_power_select <= 1'b0;
        fast_select <= 1'b1;
        repeat (250) @(posedge clk_sys);
        for (int k = 0; k < 2; k++) begin
            conv(17'h08001, 1'b0, 1'b1, 16'h8001);
            apb(1'b0, sarmc_pkg::OFS_STATUS, 32'h0);
            check({31'h0, rd[4]}, {31'h0, k == 0});
        end
        fast_select <= 1'b0;
        $display("modes test done");
    endtask
    task automatic t_regs;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, sarmc_pkg::CTRL_RST);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, er}, 32'h1);
        for (int m = 0; m < 4; m++) begin
            fast_select <= m[1];
            low_power_select <= m[0];
            apb(1'b0, 8'h04, 32'h0);
            apb(1'b0, 8'h04, 32'h0);
            check({30'h0, rd[2:1]}, {30'h0, m[1:0]});
        end
        apb(1'b1, 8'h00, 32'h71);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h71);
        $display("register test done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        t_codes;
        t_abort;
        t_pd;
        t_modes;
        t_regs;
        report_and_stop;
    end
    // Whole run is about 2000 cycles; far beyond that means a hang
    initial begin
        #(25 * 20000);
        errors++;
        report_and_stop;
    end
endmodule // sarmc_top_tb
`default_nettype wire
